// ---- dv/usb_buffer_checker_assertions.sv ----
// concurrent checks on the endpoint buffer manager ports
`timescale 1ns/1ns
`default_nettype none
module usb_buffer_checker
	import usb_buffer_pkg::*;
#(
	parameter int ENDPOINT_NUMBER = 0
)(
	input wire logic clk_in, // clock
	input wire logic reset_n_in, // reset, active low
	input wire logic full_speed_in, // speed
	input wire ep_type_e ep_type_in, // transfer type
	input wire logic pipe_in_dir_in, // IN pipe
	input wire logic dual_buffer_in, // dual mode
	input wire logic auto_increment_enable_in, // sequential
	input wire logic config_error_out, // bad setup
	input wire logic cpu_max_len_wr_in, // max length load
	input wire logic [LEN_W-1:0] cpu_max_len_in, // new max length
	input wire logic cpu_offset_wr_in, // offset load
	input wire logic cpu_data_wr_in, // byte write
	input wire logic cpu_data_rd_in, // byte read
	input wire logic cpu_done_in, // done bit
	input wire logic cpu_rdata_valid_out, // read answer
	input wire logic cpu_write_refused_out, // write refused
	input wire logic [LEN_W-1:0] buffer_address_offset_out, // offset
	input wire logic [LEN_W-1:0] maximum_packet_length_out, // max length
	input wire logic end_of_data_flag_out, // end-of-data
	input wire logic start_of_data_flag_out, // start-of-data
	input wire logic usb_rd_last_out, // last transmit byte
	input wire logic cpu_buffer_full_out, // cpu page full
	input wire logic usb_rd_valid_out, // transmit valid
	input wire logic usb_rd_ready_in, // transmit taken
	input wire logic [DATA_W-1:0] usb_rd_data_out // transmit byte
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	a_read_latency: assert property (cpu_data_rd_in && !cpu_data_wr_in |-> ##2 cpu_rdata_valid_out)
		else $error("read byte not answered after two cycles");
	a_out_refused: assert property (cpu_data_wr_in && !pipe_in_dir_in && ep_type_in != EP_INTERRUPT
		|-> cpu_write_refused_out) else $error("write to OUT pipe accepted");
	a_full_refused: assert property (cpu_data_wr_in && cpu_buffer_full_out && !dual_buffer_in
		|-> cpu_write_refused_out) else $error("write to full page accepted");
	a_speed_config: assert property (ENDPOINT_NUMBER != 0 && !full_speed_in
		&& ep_type_in inside {EP_ISOCHRONOUS, EP_BULK} |-> config_error_out)
		else $error("full speed type accepted at low speed");
	a_seq_close: assert property (auto_increment_enable_in && cpu_data_wr_in && !cpu_offset_wr_in
		&& !cpu_write_refused_out && buffer_address_offset_out + 7'h01 == maximum_packet_length_out
		|-> ##[1:2] end_of_data_flag_out) else $error("page not closed at max length");
	a_done_close: assert property (cpu_done_in && pipe_in_dir_in && !config_error_out
		&& !dual_buffer_in && !cpu_buffer_full_out |-> ##[1:2] end_of_data_flag_out)
		else $error("done did not close page");
	a_tx_hold: assert property (usb_rd_valid_out && !usb_rd_ready_in
		|=> usb_rd_valid_out && $stable(usb_rd_data_out)) else $error("transmit byte dropped");
	a_tx_spacing: assert property (usb_rd_valid_out && usb_rd_ready_in |=> !usb_rd_valid_out)
		else $error("transmit beats too close");
	a_last_beat: assert property (usb_rd_valid_out && usb_rd_ready_in && usb_rd_last_out
		|-> ##2 start_of_data_flag_out) else $error("last byte did not empty the page");
	a_max_clamp: assert property (cpu_max_len_wr_in && cpu_max_len_in > MAX_PACKET_LEN
		|=> maximum_packet_length_out == MAX_PACKET_LEN) else $error("max length not clamped");
endmodule
bind usb_endpoint_buffer_manager usb_buffer_checker #(.ENDPOINT_NUMBER(ENDPOINT_NUMBER)) chk (.*);
`default_nettype wire

// ---- dv/usb_core_model.sv ----
// usb device core stand-in: frame marks, receive packets, transmit sink
`timescale 1ns/1ns
`default_nettype none
module usb_core_model (
	input wire logic clk_in, // clock
	input wire logic reset_n_in, // reset, active low
	input wire logic slow_in, // stall transmit beats
	output logic sof_out, // start-of-frame pulse
	output logic wr_valid_out, // receive byte valid
	input wire logic wr_ready_in, // receive byte taken
	output logic [7:0] wr_data_out, // receive byte
	output logic wr_last_out, // last receive byte
	output logic wr_ok_out, // packet good
	input wire logic rd_valid_in, // transmit byte valid
	output logic rd_ready_out // transmit byte taken
);
	logic stall_reg;
	logic stuck;
	initial begin
		{sof_out, wr_valid_out, wr_last_out, wr_ok_out, stuck} = '0;
		wr_data_out = 8'h00;
	end
	// slow mode refuses the first look at every beat, so the sender must hold it
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) stall_reg <= 1'b0;
		else stall_reg <= slow_in & rd_valid_in & ~stall_reg;
	end
	assign rd_ready_out = ~slow_in | stall_reg;
	task automatic frame_start();
		@(posedge clk_in);
		#1 sof_out = 1'b1;
		@(posedge clk_in);
		#1 sof_out = 1'b0;
	endtask
	task automatic send_packet(input logic [7:0] b[$], input logic ok);
		int n;
		foreach (b[i]) begin
			wr_valid_out = 1'b1;
			wr_data_out = b[i];
			wr_last_out = (i == b.size() - 1);
			wr_ok_out = ok;
			// ready only moves at edges, so the mid-cycle look is safe
			for (n = 0; n < 2000; n++) begin
				@(negedge clk_in);
				if (wr_ready_in === 1'b1) break;
			end
			if (wr_ready_in !== 1'b1) stuck = 1'b1;
			@(posedge clk_in);
			#1;
		end
		wr_valid_out = 1'b0;
		wr_data_out = ~wr_data_out;
		wr_last_out = 1'b0;
		wr_ok_out = 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- dv/usb_endpoint_buffer_manager_bench.sv ----
// self-checking bench for the endpoint buffer manager
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
	$display("Error %0t: got %h want %h", $time, a, b); end end
module usb_endpoint_buffer_manager_bench;
	import usb_buffer_pkg::*;
	logic clk_in, reset_n_in, full_speed_in, pipe_in_dir_in, dual_buffer_in, page_select_in;
	logic auto_increment_enable_in, frame_start_done_enable_in, cpu_max_len_wr_in, cpu_offset_wr_in;
	logic cpu_data_wr_in, cpu_data_rd_in, cpu_done_in, cpu_flag_clear_in, slow;
	ep_type_e ep_type_in;
	logic [LEN_W-1:0] cpu_max_len_in, cpu_offset_in, buffer_address_offset_out;
	logic [LEN_W-1:0] endpoint_length_out, maximum_packet_length_out;
	logic [DATA_W-1:0] cpu_wdata_in, cpu_rdata_out, usb_rd_data_out, usb_wr_data_in, want;
	logic config_error_out, cpu_rdata_valid_out, cpu_write_refused_out, start_of_data_flag_out;
	logic end_of_data_flag_out, cpu_buffer_full_out, usb_buffer_full_out, frame_overdue_out;
	logic sof_in, usb_wr_valid_in, usb_wr_ready_out, usb_wr_last_in, usb_wr_ok_in;
	logic usb_rd_valid_out, usb_rd_ready_in, usb_rd_last_out;
	int miscompares, comparisons, lasts;
	logic [31:0] rng;
	logic [DATA_W-1:0] exp_q[$], pkt[$];
	usb_endpoint_buffer_manager #(.ENDPOINT_NUMBER(1), .FRAME_CYCLES(50)) dut (.*);
	usb_core_model core (.clk_in, .reset_n_in, .slow_in(slow), .sof_out(sof_in),
		.wr_valid_out(usb_wr_valid_in), .wr_ready_in(usb_wr_ready_out), .wr_data_out(usb_wr_data_in),
		.wr_last_out(usb_wr_last_in), .wr_ok_out(usb_wr_ok_in), .rd_valid_in(usb_rd_valid_out),
		.rd_ready_out(usb_rd_ready_in));
	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	task automatic final_report();
		if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic tick(input int n = 1);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick();
		s = 1'b0;
	endtask
	task automatic wait_for(ref logic s, input int lim);
		for (int i = 0; i < lim && s !== 1'b1; i++) tick();
		if (s !== 1'b1) begin
			miscompares++;
			$display("Error %0t: wait ran out", $time);
			final_report();
		end
	endtask
	// cpu read answers and transmit beats share one ordered queue
	always @(posedge clk_in) begin
		if (cpu_rdata_valid_out === 1'b1 || (usb_rd_valid_out & usb_rd_ready_in) === 1'b1) begin
			if (exp_q.size() == 0) want = 8'hxx;
			else want = exp_q.pop_front();
			`CHK(cpu_rdata_valid_out ? cpu_rdata_out : usb_rd_data_out, want)
			lasts += int'(usb_rd_valid_out & usb_rd_ready_in & usb_rd_last_out);
		end
	end
	// a receive byte that is never taken ends the run
	always @(posedge core.stuck) begin
		miscompares++;
		$display("Error %0t: receive byte never taken", $time);
		final_report();
	end
	initial begin
		{reset_n_in, full_speed_in, dual_buffer_in, page_select_in, auto_increment_enable_in} = '0;
		{frame_start_done_enable_in, cpu_max_len_wr_in, cpu_offset_wr_in, cpu_data_wr_in} = '0;
		{cpu_data_rd_in, cpu_done_in, cpu_flag_clear_in, slow} = '0;
		pipe_in_dir_in = 1'b1;
		ep_type_in = EP_CONTROL;
		{cpu_max_len_in, cpu_offset_in, cpu_wdata_in} = '0;
		{rng, miscompares, comparisons, lasts} = {32'h0000002d, 96'h0};
		tick(2);
		reset_n_in = 1'b1;
		`CHK(maximum_packet_length_out, EP0_DEFAULT_LEN)
		for (int t = 0; t < 8; t++) begin
			ep_type_in = ep_type_e'(t[1:0]);
			full_speed_in = t[2];
			tick();
			`CHK(config_error_out, !t[2] && t[0])
		end
		tick(50);
		`CHK(frame_overdue_out, 1'b1)
		cpu_max_len_in = 7'h7f;
		pulse(cpu_max_len_wr_in);
		`CHK(maximum_packet_length_out, MAX_PACKET_LEN)
		pipe_in_dir_in = 1'b0;
		page_select_in = 1'b1;
		cpu_data_wr_in = 1'b1;
		#1;
		`CHK(cpu_write_refused_out, 1'b1)
		tick();
		cpu_data_wr_in = 1'b0;
		for (int i = 0; i < 40; i++) begin
			rng = xs(rng);
			pkt.push_back(rng[7:0]);
		end
		fork
			core.send_packet(pkt, 1'b1);
			begin
				tick(45);
				`CHK(usb_wr_ready_out, 1'b0)
				core.frame_start();
			end
		join
		wait_for(start_of_data_flag_out, 200);
		`CHK(endpoint_length_out, 7'h28)
		`CHK(usb_buffer_full_out, 1'b1)
		cpu_offset_in = 7'h07;
		pulse(cpu_offset_wr_in);
		`CHK(buffer_address_offset_out, 7'h07)
		exp_q.push_back(pkt[7]);
		pulse(cpu_data_rd_in);
		auto_increment_enable_in = 1'b1;
		cpu_offset_in = 7'h00;
		pulse(cpu_offset_wr_in);
		cpu_data_rd_in = 1'b1;
		foreach (pkt[i]) begin
			exp_q.push_back(pkt[i]);
			tick();
		end
		cpu_data_rd_in = 1'b0;
		tick(3);
		`CHK(end_of_data_flag_out, 1'b1)
		pulse(cpu_flag_clear_in);
		core.frame_start();
		core.send_packet(pkt[0:2], 1'b0);
		tick(20);
		`CHK(start_of_data_flag_out, 1'b0)
		`CHK(endpoint_length_out, 7'h28)
		pipe_in_dir_in = 1'b1;
		slow = 1'b1;
		reset_n_in = 1'b0;
		tick(2);
		reset_n_in = 1'b1;
		cpu_max_len_in = 7'h04;
		pulse(cpu_max_len_wr_in);
		// closing by max length, by done, then by start of frame
		for (int m = 0; m < 3; m++) begin
			cpu_data_wr_in = 1'b1;
			for (int i = 0; i < 4 - m; i++) begin
				rng = xs(rng);
				cpu_wdata_in = rng[7:0];
				exp_q.push_back(rng[7:0]);
				tick();
			end
			cpu_data_wr_in = 1'b0;
			if (m == 1) pulse(cpu_done_in);
			frame_start_done_enable_in = (m == 2);
			if (m == 2) core.frame_start();
			tick(2);
			`CHK(end_of_data_flag_out, 1'b1)
			`CHK(cpu_buffer_full_out, 1'b1)
			cpu_data_wr_in = 1'b1;
			#1;
			`CHK(cpu_write_refused_out, 1'b1)
			tick();
			{cpu_data_wr_in, frame_start_done_enable_in} = 2'b00;
			pulse(cpu_flag_clear_in);
			core.frame_start();
			wait_for(start_of_data_flag_out, 100);
			pulse(cpu_flag_clear_in);
		end
		// dual mode: a closed cpu page swaps over to the usb side by itself
		dual_buffer_in = 1'b1;
		cpu_data_wr_in = 1'b1;
		for (int i = 0; i < 4; i++) begin
			rng = xs(rng);
			cpu_wdata_in = rng[7:0];
			exp_q.push_back(rng[7:0]);
			tick();
		end
		cpu_data_wr_in = 1'b0;
		tick(2);
		`CHK(cpu_buffer_full_out, 1'b0)
		`CHK(usb_buffer_full_out, 1'b1)
		core.frame_start();
		wait_for(start_of_data_flag_out, 100);
		tick(5);
		`CHK(exp_q.size(), 0)
		`CHK(lasts, 4)
		final_report();
	end
endmodule
`default_nettype wire

// ---- rtl/buffer_page_memory.sv ----
// two-page byte memory with one write and one registered read port
`timescale 1ns/1ns
`default_nettype none
module buffer_page_memory #(
	parameter int ADDR_W = 7,
	parameter int DATA_W = 8
)(
	input wire logic clk_in, // module clock
	input wire logic reset_n_in, // async reset, active low
	buffer_mem_if.memory mem // access port
);
	logic [DATA_W-1:0] store [0:(1<<ADDR_W)-1];
	logic [DATA_W-1:0] rd_data_reg;

	always_ff @(posedge clk_in) begin
		if (mem.wr_en) begin
			store[mem.wr_addr] <= mem.wr_data;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rd_data_reg <= '0;
		end else if (mem.rd_en) begin
			rd_data_reg <= store[mem.rd_addr];
		end
	end

	assign mem.rd_data = rd_data_reg;
endmodule
`default_nettype wire

// ---- rtl/sync_fifo.sv ----
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module sync_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 32
)(
	input wire logic clk_in, // module clock
	input wire logic reset_n_in, // async reset, active low
	input wire logic in_valid_in, // write request
	output logic in_ready_out, // space available
	input wire logic [WIDTH-1:0] in_data_in, // write data
	output logic out_valid_out, // entry available
	input wire logic out_ready_in, // consumer takes entry
	output logic [WIDTH-1:0] out_data_out // head entry
);
	localparam int PTR_W = $clog2(DEPTH);
	logic [WIDTH-1:0] slots [0:DEPTH-1];
	logic [PTR_W:0] wr_ptr_reg;
	logic [PTR_W:0] rd_ptr_reg;
	logic do_push;
	logic do_pop;

	assign out_valid_out = (wr_ptr_reg != rd_ptr_reg);
	assign in_ready_out = !((wr_ptr_reg[PTR_W] != rd_ptr_reg[PTR_W]) &&
		(wr_ptr_reg[PTR_W-1:0] == rd_ptr_reg[PTR_W-1:0]));
	assign do_push = in_valid_in && in_ready_out;
	assign do_pop = out_valid_out && out_ready_in;
	assign out_data_out = slots[rd_ptr_reg[PTR_W-1:0]];

	always_ff @(posedge clk_in) begin
		if (do_push) begin
			slots[wr_ptr_reg[PTR_W-1:0]] <= in_data_in;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (do_push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (do_pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ---- rtl/usb_endpoint_buffer_manager.sv ----
// endpoint buffer manager between the usb device core and the cpu
`timescale 1ns/1ns
`default_nettype none
module usb_endpoint_buffer_manager #(
	parameter int ENDPOINT_NUMBER = 0,
	parameter int FIFO_DEPTH = usb_buffer_pkg::FIFO_DEPTH_DEFAULT,
	parameter int FRAME_CYCLES = usb_buffer_pkg::FRAME_CYCLES_DEFAULT
)(
	input wire logic clk_in, // module clock, 25 MHz
	input wire logic reset_n_in, // async reset, active low
	input wire logic full_speed_in, // 1 = full speed operation
	input wire usb_buffer_pkg::ep_type_e ep_type_in, // transfer type
	input wire logic pipe_in_dir_in, // 1 = device-to-host pipe
	input wire logic dual_buffer_in, // 1 = dual buffer mode
	input wire logic page_select_in, // page used in single buffer mode
	input wire logic auto_increment_enable_in, // sequential access
	input wire logic frame_start_done_enable_in, // close cpu buffer on sof, IN pipe only
	output logic config_error_out, // illegal type/speed/direction
	input wire logic cpu_max_len_wr_in, // load maximum packet length
	input wire logic [usb_buffer_pkg::LEN_W-1:0] cpu_max_len_in, // new length
	input wire logic cpu_offset_wr_in, // load address offset
	input wire logic [usb_buffer_pkg::LEN_W-1:0] cpu_offset_in, // new offset
	input wire logic cpu_data_wr_in, // write data port
	input wire logic [usb_buffer_pkg::DATA_W-1:0] cpu_wdata_in, // write byte
	input wire logic cpu_data_rd_in, // read data port
	input wire logic cpu_done_in, // done bit set by software
	input wire logic cpu_flag_clear_in, // clear both data flags
	output logic [usb_buffer_pkg::DATA_W-1:0] cpu_rdata_out, // read byte
	output logic cpu_rdata_valid_out, // read byte valid pulse
	output logic cpu_write_refused_out, // write ignored pulse
	output logic [usb_buffer_pkg::LEN_W-1:0] buffer_address_offset_out, // offset
	output logic [usb_buffer_pkg::LEN_W-1:0] endpoint_length_out, // cpu page length
	output logic [usb_buffer_pkg::LEN_W-1:0] maximum_packet_length_out, // max length
	output logic start_of_data_flag_out, // sticky start-of-data
	output logic end_of_data_flag_out, // sticky end-of-data
	output logic cpu_buffer_full_out, // cpu page full
	output logic usb_buffer_full_out, // usb page full
	output logic frame_overdue_out, // no sof for a whole frame
	input wire logic sof_in, // start-of-frame pulse
	input wire logic usb_wr_valid_in, // received byte valid
	output logic usb_wr_ready_out, // received byte taken
	input wire logic [usb_buffer_pkg::DATA_W-1:0] usb_wr_data_in, // received byte
	input wire logic usb_wr_last_in, // last byte of packet
	input wire logic usb_wr_ok_in, // packet received correctly, with last
	output logic usb_rd_valid_out, // transmit byte valid
	input wire logic usb_rd_ready_in, // transmit byte taken
	output logic [usb_buffer_pkg::DATA_W-1:0] usb_rd_data_out, // transmit byte
	output logic usb_rd_last_out // last transmit byte
);
	import usb_buffer_pkg::*;

	function automatic logic [MEM_ADDR_W-1:0] page_addr(input logic page,
		input logic [LEN_W-1:0] offset);
		page_addr = {page, offset[PAGE_OFFSET_W-1:0]};
	endfunction

	buffer_mem_if #(.ADDR_W(MEM_ADDR_W), .DATA_W(DATA_W)) mem ();

	ep_type_e eff_type;
	logic dir_in;
	logic cfg_err;
	logic cpu_page_reg;
	logic usb_page;
	logic [PAGE_COUNT-1:0] page_full_reg;
	logic [LEN_W-1:0] page_len_reg [0:PAGE_COUNT-1];
	logic [LEN_W-1:0] max_len_reg;
	logic [LEN_W-1:0] offset_reg;
	logic [LEN_W-1:0] offset_plus;
	logic [LEN_W-1:0] offset_after;
	logic [LEN_W-1:0] close_len;
	logic sod_reg;
	logic eod_reg;
	usb_state_e usb_state_reg;
	logic [LEN_W-1:0] usb_count_reg;
	logic usb_overflow_reg;
	logic usb_pending_reg;
	logic usb_valid_reg;
	logic [DATA_W-1:0] usb_data_reg;
	logic cpu_pending_reg;
	logic cpu_valid_reg;
	logic [DATA_W-1:0] cpu_data_reg;
	logic [FRAME_CNT_W-1:0] frame_cnt_reg;
	logic cpu_wr_ok;
	logic cpu_rd_ok;
	logic cpu_step;
	logic cpu_close_in;
	logic cpu_close_out;
	logic swap_now;
	logic fifo_valid;
	logic fifo_ready;
	logic [ENTRY_W-1:0] fifo_entry;
	logic drain;
	logic drain_fits;
	logic write_done_ok;
	logic write_done_bad;
	logic usb_issue;
	logic read_done;

	// endpoint 0 is forced to control whatever the type input says
	assign eff_type = (ENDPOINT_NUMBER == 0) ? EP_CONTROL : ep_type_in;
	assign dir_in = (eff_type == EP_INTERRUPT) || pipe_in_dir_in;
	assign cfg_err = ((eff_type == EP_ISOCHRONOUS) && !full_speed_in) ||
		((eff_type == EP_BULK) && !full_speed_in) ||
		((eff_type == EP_INTERRUPT) && !pipe_in_dir_in);
	assign config_error_out = cfg_err;

	// single mode keeps both sides on one page, dual mode keeps them apart
	assign usb_page = dual_buffer_in ? !cpu_page_reg : cpu_page_reg;

	// cpu only writes an IN pipe, and only while its page is open
	assign cpu_wr_ok = cpu_data_wr_in && dir_in && !cfg_err && !page_full_reg[cpu_page_reg];
	assign cpu_write_refused_out = cpu_data_wr_in && !cpu_wr_ok;
	assign cpu_rd_ok = cpu_data_rd_in && !cpu_wr_ok;
	assign cpu_step = (cpu_wr_ok || cpu_rd_ok) && auto_increment_enable_in;
	assign offset_plus = offset_reg + LEN_ONE;
	assign offset_after = cpu_step ? offset_plus : offset_reg;
	// random writes keep the programmed length, sequential ones report the count
	assign close_len = auto_increment_enable_in ? offset_after : max_len_reg;

	assign cpu_close_in = dir_in && !page_full_reg[cpu_page_reg] &&
		((cpu_wr_ok && auto_increment_enable_in && offset_plus == max_len_reg) ||
		cpu_done_in ||
		(sof_in && frame_start_done_enable_in));
	assign cpu_close_out = !dir_in && page_full_reg[cpu_page_reg] &&
		((cpu_rd_ok && auto_increment_enable_in &&
		offset_plus == page_len_reg[cpu_page_reg]) ||
		cpu_done_in);

	// swap only while the usb side is between transfers
	assign swap_now = dual_buffer_in && (usb_state_reg == USB_IDLE) &&
		(dir_in ? (page_full_reg[cpu_page_reg] && !page_full_reg[usb_page]) :
		(!page_full_reg[cpu_page_reg] && page_full_reg[usb_page]));

	sync_fifo #(.WIDTH(ENTRY_W), .DEPTH(FIFO_DEPTH)) rx_fifo (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.in_valid_in(usb_wr_valid_in),
		.in_ready_out(usb_wr_ready_out),
		.in_data_in({usb_wr_ok_in, usb_wr_last_in, usb_wr_data_in}),
		.out_valid_out(fifo_valid),
		.out_ready_in(fifo_ready),
		.out_data_out(fifo_entry)
	);

	// cpu owns the write port when it writes; the fifo waits and backs up
	assign drain = fifo_valid && (usb_state_reg == USB_WRITE) && !cpu_wr_ok;
	assign fifo_ready = drain;
	assign drain_fits = !usb_overflow_reg && (usb_count_reg < max_len_reg);
	assign write_done_ok = drain && fifo_entry[ENTRY_LAST_BIT] &&
		fifo_entry[ENTRY_OK_BIT] && drain_fits;
	assign write_done_bad = drain && fifo_entry[ENTRY_LAST_BIT] && !write_done_ok;

	assign usb_issue = (usb_state_reg == USB_READ) && !cpu_rd_ok && !usb_pending_reg &&
		!usb_valid_reg && (usb_count_reg != page_len_reg[usb_page]);
	assign read_done = (usb_state_reg == USB_READ) && !usb_pending_reg && !usb_valid_reg &&
		(usb_count_reg == page_len_reg[usb_page]);

	assign mem.wr_en = cpu_wr_ok || (drain && drain_fits);
	assign mem.wr_addr = cpu_wr_ok ? page_addr(cpu_page_reg, offset_reg) :
		page_addr(usb_page, usb_count_reg);
	assign mem.wr_data = cpu_wr_ok ? cpu_wdata_in : fifo_entry[DATA_W-1:0];
	assign mem.rd_en = cpu_rd_ok || usb_issue;
	assign mem.rd_addr = cpu_rd_ok ? page_addr(cpu_page_reg, offset_reg) :
		page_addr(usb_page, usb_count_reg);

	buffer_page_memory #(.ADDR_W(MEM_ADDR_W), .DATA_W(DATA_W)) pages (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.mem(mem)
	);

	// maximum length is clamped so no endpoint can exceed one packet
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			max_len_reg <= EP0_DEFAULT_LEN;
		end else if (cpu_max_len_wr_in) begin
			max_len_reg <= (cpu_max_len_in > MAX_PACKET_LEN) ? MAX_PACKET_LEN :
				cpu_max_len_in;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			offset_reg <= LEN_ZERO;
		end else if (cpu_offset_wr_in) begin
			offset_reg <= cpu_offset_in;
		end else if (cpu_close_in || cpu_close_out) begin
			offset_reg <= LEN_ZERO;
		end else if (cpu_step) begin
			offset_reg <= offset_plus;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cpu_page_reg <= 1'b0;
		end else if (!dual_buffer_in) begin
			cpu_page_reg <= page_select_in;
		end else if (swap_now) begin
			cpu_page_reg <= !cpu_page_reg;
		end
	end

	// in single mode both sides index the same page; their events never overlap
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			page_full_reg <= '0;
			for (int i = 0; i < PAGE_COUNT; i++) begin
				page_len_reg[i] <= LEN_ZERO;
			end
		end else begin
			if (cpu_close_in) begin
				page_full_reg[cpu_page_reg] <= 1'b1;
				page_len_reg[cpu_page_reg] <= close_len;
			end
			if (cpu_close_out) begin
				page_full_reg[cpu_page_reg] <= 1'b0;
			end
			if (write_done_ok) begin
				page_full_reg[usb_page] <= 1'b1;
				page_len_reg[usb_page] <= usb_count_reg + LEN_ONE;
			end
			if (read_done) begin
				page_full_reg[usb_page] <= 1'b0;
			end
		end
	end

	// a set arriving with the clear wins
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sod_reg <= 1'b0;
		end else if (write_done_ok || read_done) begin
			sod_reg <= 1'b1;
		end else if (cpu_flag_clear_in) begin
			sod_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			eod_reg <= 1'b0;
		end else if (cpu_close_in || cpu_close_out) begin
			eod_reg <= 1'b1;
		end else if (cpu_flag_clear_in) begin
			eod_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			usb_state_reg <= USB_IDLE;
		end else begin
			case (usb_state_reg)
				USB_IDLE: begin
					if (sof_in && !cfg_err && dir_in && page_full_reg[usb_page]) begin
						usb_state_reg <= USB_READ;
					end else if (sof_in && !cfg_err && !dir_in && !page_full_reg[usb_page]) begin
						usb_state_reg <= USB_WRITE;
					end
				end
				USB_WRITE: begin
					if (write_done_ok || write_done_bad) begin
						usb_state_reg <= USB_IDLE;
					end
				end
				USB_READ: begin
					if (read_done) begin
						usb_state_reg <= USB_IDLE;
					end
				end
				default: begin
					usb_state_reg <= USB_IDLE;
				end
			endcase
		end
	end

	// one counter serves as received-byte count and as transmit index
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			usb_count_reg <= LEN_ZERO;
			usb_overflow_reg <= 1'b0;
		end else if (usb_state_reg == USB_IDLE) begin
			usb_count_reg <= LEN_ZERO;
			usb_overflow_reg <= 1'b0;
		end else if (drain && drain_fits) begin
			usb_count_reg <= usb_count_reg + LEN_ONE;
		end else if (drain) begin
			usb_overflow_reg <= 1'b1;
		end else if (usb_pending_reg) begin
			usb_count_reg <= usb_count_reg + LEN_ONE;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			usb_pending_reg <= 1'b0;
			usb_valid_reg <= 1'b0;
			usb_data_reg <= '0;
		end else begin
			usb_pending_reg <= usb_issue;
			if (usb_pending_reg) begin
				usb_valid_reg <= 1'b1;
				usb_data_reg <= mem.rd_data;
			end else if (usb_valid_reg && usb_rd_ready_in) begin
				usb_valid_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cpu_pending_reg <= 1'b0;
			cpu_valid_reg <= 1'b0;
			cpu_data_reg <= '0;
		end else begin
			cpu_pending_reg <= cpu_rd_ok;
			cpu_valid_reg <= cpu_pending_reg;
			if (cpu_pending_reg) begin
				cpu_data_reg <= mem.rd_data;
			end
		end
	end

	// a missing start of frame shows after one frame period
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			frame_cnt_reg <= '0;
		end else if (sof_in) begin
			frame_cnt_reg <= '0;
		end else if (frame_cnt_reg != FRAME_CNT_W'(FRAME_CYCLES)) begin
			frame_cnt_reg <= frame_cnt_reg + 1'b1;
		end
	end

	assign frame_overdue_out = (frame_cnt_reg == FRAME_CNT_W'(FRAME_CYCLES));
	assign cpu_rdata_out = cpu_data_reg;
	assign cpu_rdata_valid_out = cpu_valid_reg;
	assign buffer_address_offset_out = offset_reg;
	assign endpoint_length_out = page_len_reg[cpu_page_reg];
	assign maximum_packet_length_out = max_len_reg;
	assign start_of_data_flag_out = sod_reg;
	assign end_of_data_flag_out = eod_reg;
	assign cpu_buffer_full_out = page_full_reg[cpu_page_reg];
	assign usb_buffer_full_out = page_full_reg[usb_page];
	assign usb_rd_valid_out = usb_valid_reg;
	assign usb_rd_data_out = usb_data_reg;
	assign usb_rd_last_out = usb_valid_reg && (usb_count_reg == page_len_reg[usb_page]);
endmodule
`default_nettype wire

// ---- shared/buffer_mem_if.sv ----
// carrier between the buffer manager and its page memory
`timescale 1ns/1ns
`default_nettype none
interface buffer_mem_if #(parameter int ADDR_W = 7, parameter int DATA_W = 8);
	logic wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic rd_en;
	logic [ADDR_W-1:0] rd_addr;
	logic [DATA_W-1:0] rd_data;
	modport master (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
	modport memory (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface
`default_nettype wire

// ---- shared/usb_buffer_pkg.sv ----
// constants and types shared by the endpoint buffer manager
`default_nettype none
package usb_buffer_pkg;
	localparam int DATA_W = 8;
	localparam int LEN_W = 7;
	localparam int PAGE_OFFSET_W = 6;
	localparam int MEM_ADDR_W = PAGE_OFFSET_W + 1;
	localparam int PAGE_COUNT = 2;
	localparam logic [LEN_W-1:0] EP0_DEFAULT_LEN = 7'h08;
	localparam logic [LEN_W-1:0] MAX_PACKET_LEN = 7'h40;
	localparam logic [LEN_W-1:0] LEN_ZERO = 7'h00;
	localparam logic [LEN_W-1:0] LEN_ONE = 7'h01;
	localparam int FIFO_DEPTH_DEFAULT = 32;
	localparam int ENTRY_LAST_BIT = DATA_W;
	localparam int ENTRY_OK_BIT = DATA_W + 1;
	localparam int ENTRY_W = DATA_W + 2;
	localparam int FRAME_PERIOD_NS = 1000000;
	localparam int CLK_PERIOD_NS = 40;
	localparam int FRAME_CYCLES_DEFAULT = FRAME_PERIOD_NS / CLK_PERIOD_NS;
	localparam int FRAME_CNT_W = 16;
	typedef enum logic [1:0] {
		EP_CONTROL = 2'b00,
		EP_ISOCHRONOUS = 2'b01,
		EP_INTERRUPT = 2'b10,
		EP_BULK = 2'b11
	} ep_type_e;
	typedef enum logic [1:0] {
		USB_IDLE = 2'b00,
		USB_WRITE = 2'b01,
		USB_READ = 2'b10
	} usb_state_e;
endpackage
`default_nettype wire
